//--- rtl/tmr0_pkg.sv
// constants and register map of the timer0 control and compare block
package tmr0_pkg;
    localparam logic [2:0] ADDR_CONTROL  = 3'h0;
    localparam logic [2:0] ADDR_COUNTER  = 3'h1;
    localparam logic [2:0] ADDR_COMPARE  = 3'h2;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
    localparam logic [2:0] ADDR_FLAGS    = 3'h4;

    localparam int BIT_FORCE    = 7;
    localparam int BIT_WGM_LO   = 6;
    localparam int BIT_COM_HI   = 5;
    localparam int BIT_COM_LO   = 4;
    localparam int BIT_WGM_HI   = 3;
    localparam int BIT_CMP_IRQ  = 1;
    localparam int BIT_OVF_IRQ  = 0;

    localparam logic [7:0] RESET_CONTROL  = 8'h00;
    localparam logic [7:0] RESET_IRQ_MASK = 8'h00;
    localparam logic [7:0] RESET_COUNTER  = 8'h00;
    localparam logic [7:0] RESET_COMPARE  = 8'h00;
    localparam logic [7:0] COUNT_MAX      = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM   = 8'h00;

    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PHASE  = 2'h1;
    localparam logic [1:0] WGM_CTC    = 2'h2;
    localparam logic [1:0] WGM_FAST   = 2'h3;

    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    localparam logic [2:0] CS_STOP  = 3'h0;
    localparam logic [2:0] CS_DIV1  = 3'h1;
    localparam logic [2:0] CS_DIV8  = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    localparam logic [9:0] PRESCALE_WRAP = 10'h3FF;
    localparam logic [9:0] TAP8_MASK     = 10'h007;
    localparam logic [9:0] TAP64_MASK    = 10'h03F;
    localparam logic [9:0] TAP256_MASK   = 10'h0FF;
    localparam logic [9:0] TAP1024_MASK  = 10'h3FF;
endpackage

//--- rtl/tmr0_ctrl.sv
// timer0 counter, compare unit, waveform output and register port
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module tmr0_ctrl (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // core interrupt hooks
    input  wire logic       global_irq_en,
    input  wire logic       cmp_vector_ack,
    input  wire logic       ovf_vector_ack,
    output logic            cmp_irq_req,
    output logic            ovf_irq_req,
    // pins
    input  wire logic       external_count_pin,
    output logic            compare_output_pin,
    output logic            compare_output_override
);
    // register file state
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] mask_ff, nxt_mask;
    logic [7:0] cmp_ff, nxt_cmp;
    logic [7:0] cmp_buf_ff, nxt_cmp_buf;
    logic [7:0] rdata_ff, nxt_rdata;
    // counter state
    logic [7:0] cnt_ff, nxt_cnt;
    logic       down_ff, nxt_down;
    logic       block_ff, nxt_block;
    logic       oc_ff, nxt_oc;
    logic       cmpf_ff, nxt_cmpf;
    logic       ovff_ff, nxt_ovff;
    logic       cirq_ff, nxt_cirq;
    logic       oirq_ff, nxt_oirq;
    logic       ovr_ff, nxt_ovr;
    // clock source state
    logic [9:0] pre_ff, nxt_pre;
    logic [2:0] ext_sync_ff, nxt_ext_sync;
    logic       ext_lvl_ff, nxt_ext_lvl;

    logic [1:0] wgm;
    logic [1:0] com;
    logic [2:0] cs;
    logic       is_pwm;
    logic       tick;
    logic       ext_rise;
    logic       ext_fall;
    logic       wr_ctrl;
    logic       wr_cnt;
    logic       force_cmp;
    logic       match;
    logic       cmp_at_top;
    logic       ovf_event;
    logic [7:0] top_val;

    assign wgm    = {ctrl_ff[tmr0_pkg::BIT_WGM_HI],
                     ctrl_ff[tmr0_pkg::BIT_WGM_LO]};
    assign com    = ctrl_ff[tmr0_pkg::BIT_COM_HI:tmr0_pkg::BIT_COM_LO];
    assign cs     = ctrl_ff[2:0];
    assign is_pwm = wgm[0];
    assign wr_ctrl = reg_wr && reg_addr == tmr0_pkg::ADDR_CONTROL;
    assign wr_cnt  = reg_wr && reg_addr == tmr0_pkg::ADDR_COUNTER;
    // strobe acts with the settings already held, not the ones written
    assign force_cmp = wr_ctrl && reg_wdata[tmr0_pkg::BIT_FORCE]
                       && !is_pwm;
    assign top_val = (wgm == tmr0_pkg::WGM_CTC) ? cmp_ff
                                                : tmr0_pkg::COUNT_MAX;

    // external pin: three stages, edge once the last two agree
    always_comb begin
        nxt_ext_sync = {ext_sync_ff[1:0], external_count_pin};
        nxt_ext_lvl  = ext_lvl_ff;
        if (ext_sync_ff[2] == ext_sync_ff[1]) begin
            nxt_ext_lvl = ext_sync_ff[2];
        end
        nxt_pre = pre_ff + 10'h001;
    end
    // pin is read regardless of its port direction
    assign ext_rise = !ext_lvl_ff && nxt_ext_lvl;
    assign ext_fall = ext_lvl_ff && !nxt_ext_lvl;

    always_comb begin
        case (cs)
            tmr0_pkg::CS_STOP:     tick = 1'b0;
            tmr0_pkg::CS_DIV1:     tick = 1'b1;
            tmr0_pkg::CS_DIV8:
                tick = (pre_ff & tmr0_pkg::TAP8_MASK) == tmr0_pkg::TAP8_MASK;
            tmr0_pkg::CS_DIV64:
                tick = (pre_ff & tmr0_pkg::TAP64_MASK)
                       == tmr0_pkg::TAP64_MASK;
            tmr0_pkg::CS_DIV256:
                tick = (pre_ff & tmr0_pkg::TAP256_MASK)
                       == tmr0_pkg::TAP256_MASK;
            tmr0_pkg::CS_DIV1024:
                tick = pre_ff == tmr0_pkg::TAP1024_MASK;
            tmr0_pkg::CS_EXT_FALL: tick = ext_fall;
            tmr0_pkg::CS_EXT_RISE: tick = ext_rise;
            default:               tick = 1'b0;
        endcase
    end

    // compare is evaluated against the active compare value on every tick except the first tick after a counter write
    assign match = tick && !block_ff && cnt_ff == cmp_ff;
    assign cmp_at_top = cmp_ff == tmr0_pkg::COUNT_MAX && com[1];

    // counter, direction, waveform, compare update and overflow event
    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_down  = down_ff;
        nxt_oc    = oc_ff;
        nxt_cmp   = cmp_ff;
        nxt_block = block_ff;
        ovf_event = 1'b0;
        if (tick) begin
            nxt_block = 1'b0;
            case (wgm)
                tmr0_pkg::WGM_PHASE: begin
                    if (!down_ff && cnt_ff == tmr0_pkg::COUNT_MAX) begin
                        nxt_down = 1'b1;
                        nxt_cnt  = cnt_ff - 8'h01;
                        nxt_cmp  = cmp_buf_ff;
                    end else if (down_ff &&
                                 cnt_ff == tmr0_pkg::COUNT_BOTTOM) begin
                        nxt_down  = 1'b0;
                        nxt_cnt   = cnt_ff + 8'h01;
                        ovf_event = 1'b1;
                    end else if (down_ff) begin
                        nxt_cnt = cnt_ff - 8'h01;
                    end else begin
                        nxt_cnt = cnt_ff + 8'h01;
                    end
                    if (com[1]) begin
                        if (cmp_at_top) begin
                            if (cnt_ff == tmr0_pkg::COUNT_MAX) begin
                                // level at top equals a down-count match
                                nxt_oc = !com[0];
                            end
                        end else if (match) begin
                            // bottom turns upward, so it acts as up-count
                            nxt_oc = com[0] ^ (down_ff && cnt_ff
                                     != tmr0_pkg::COUNT_BOTTOM);
                        end
                    end
                end
                tmr0_pkg::WGM_FAST: begin
                    nxt_down = 1'b0;
                    if (cnt_ff == tmr0_pkg::COUNT_MAX) begin
                        nxt_cnt   = tmr0_pkg::COUNT_BOTTOM;
                        nxt_cmp   = cmp_buf_ff;
                        ovf_event = 1'b1;
                        if (com[1]) begin
                            nxt_oc = !com[0];
                        end
                    end else begin
                        nxt_cnt = cnt_ff + 8'h01;
                    end
                    if (match && com[1] && !cmp_at_top) begin
                        nxt_oc = com[0];
                    end
                end
                default: begin
                    nxt_down = 1'b0;
                    if (cnt_ff == top_val) begin
                        nxt_cnt = tmr0_pkg::COUNT_BOTTOM;
                    end else begin
                        nxt_cnt = cnt_ff + 8'h01;
                    end
                    if (cnt_ff == tmr0_pkg::COUNT_MAX) begin
                        ovf_event = 1'b1;
                    end
                end
            endcase
        end
        // non-PWM action shared by real and forced matches
        if (!is_pwm && (match || force_cmp)) begin
            case (com)
                tmr0_pkg::COM_TOGGLE: nxt_oc = !oc_ff;
                tmr0_pkg::COM_CLEAR:  nxt_oc = 1'b0;
                tmr0_pkg::COM_SET:    nxt_oc = 1'b1;
                default:              nxt_oc = oc_ff;
            endcase
        end
        if (!is_pwm) begin
            nxt_cmp = cmp_buf_ff;
        end
        if (wr_cnt) begin
            nxt_cnt   = reg_wdata;
            nxt_block = 1'b1;
        end
    end

    // flags: set beats clear
    always_comb begin
        nxt_cmpf = cmpf_ff;
        nxt_ovff = ovff_ff;
        if (cmp_vector_ack) begin
            nxt_cmpf = 1'b0;
        end
        if (ovf_vector_ack) begin
            nxt_ovff = 1'b0;
        end
        if (reg_wr && reg_addr == tmr0_pkg::ADDR_FLAGS) begin
            if (reg_wdata[tmr0_pkg::BIT_CMP_IRQ]) begin
                nxt_cmpf = 1'b0;
            end
            if (reg_wdata[tmr0_pkg::BIT_OVF_IRQ]) begin
                nxt_ovff = 1'b0;
            end
        end
        if (match) begin
            nxt_cmpf = 1'b1;
        end
        if (ovf_event) begin
            nxt_ovff = 1'b1;
        end
        nxt_cirq = mask_ff[tmr0_pkg::BIT_CMP_IRQ] && global_irq_en
                   && cmpf_ff;
        nxt_oirq = mask_ff[tmr0_pkg::BIT_OVF_IRQ] && global_irq_en
                   && ovff_ff;
        nxt_ovr  = com != tmr0_pkg::COM_OFF;
    end

    // register writes and read data
    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_mask    = mask_ff;
        nxt_cmp_buf = cmp_buf_ff;
        nxt_rdata   = 8'h00;
        if (wr_ctrl) begin
            nxt_ctrl = {1'b0, reg_wdata[6:0]};
        end
        if (reg_wr && reg_addr == tmr0_pkg::ADDR_COMPARE) begin
            nxt_cmp_buf = reg_wdata;
        end
        if (reg_wr && reg_addr == tmr0_pkg::ADDR_IRQ_MASK) begin
            nxt_mask = reg_wdata;
        end
        if (reg_rd) begin
            case (reg_addr)
                tmr0_pkg::ADDR_CONTROL:  nxt_rdata = ctrl_ff;
                tmr0_pkg::ADDR_COUNTER:  nxt_rdata = cnt_ff;
                tmr0_pkg::ADDR_COMPARE:  nxt_rdata = cmp_buf_ff;
                tmr0_pkg::ADDR_IRQ_MASK: nxt_rdata = mask_ff;
                tmr0_pkg::ADDR_FLAGS:    nxt_rdata = {6'h00, cmpf_ff, ovff_ff};
                default:                 nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrl_ff     <= tmr0_pkg::RESET_CONTROL;
            mask_ff     <= tmr0_pkg::RESET_IRQ_MASK;
            cmp_ff      <= tmr0_pkg::RESET_COMPARE;
            cmp_buf_ff  <= tmr0_pkg::RESET_COMPARE;
            rdata_ff    <= 8'h00;
            cnt_ff      <= tmr0_pkg::RESET_COUNTER;
            down_ff     <= 1'b0;
            block_ff    <= 1'b0;
            oc_ff       <= 1'b0;
            cmpf_ff     <= 1'b0;
            ovff_ff     <= 1'b0;
            cirq_ff     <= 1'b0;
            oirq_ff     <= 1'b0;
            ovr_ff      <= 1'b0;
            pre_ff      <= 10'h000;
            ext_sync_ff <= 3'h0;
            ext_lvl_ff  <= 1'b0;
        end else begin
            ctrl_ff     <= nxt_ctrl;
            mask_ff     <= nxt_mask;
            cmp_ff      <= nxt_cmp;
            cmp_buf_ff  <= nxt_cmp_buf;
            rdata_ff    <= nxt_rdata;
            cnt_ff      <= nxt_cnt;
            down_ff     <= nxt_down;
            block_ff    <= nxt_block;
            oc_ff       <= nxt_oc;
            cmpf_ff     <= nxt_cmpf;
            ovff_ff     <= nxt_ovff;
            cirq_ff     <= nxt_cirq;
            oirq_ff     <= nxt_oirq;
            ovr_ff      <= nxt_ovr;
            pre_ff      <= nxt_pre;
            ext_sync_ff <= nxt_ext_sync;
            ext_lvl_ff  <= nxt_ext_lvl;
        end
    end

    assign reg_rdata               = rdata_ff;
    assign cmp_irq_req             = cirq_ff;
    assign ovf_irq_req             = oirq_ff;
    assign compare_output_pin      = oc_ff;
    assign compare_output_override = ovr_ff;
endmodule

//--- tb/tmr0_chk.sv
// port assertions for the timer0 control and compare block
`timescale 1ns/10ps
module tmr0_chk (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // interrupt hooks and pin
    input wire logic       global_irq_en,
    input wire logic       cmp_vector_ack,
    input wire logic       cmp_irq_req,
    input wire logic       ovf_irq_req,
    input wire logic       compare_output_pin,
    input wire logic       compare_output_override
);
    logic       ctl_wr;
    logic [7:0] ctl_ff;
    logic [7:0] nxt_ctl;
    logic [7:0] msk_ff;
    logic [7:0] nxt_msk;

    // shadow of what software last wrote, since the bodies are unseen
    always_comb begin
        ctl_wr  = reg_wr && reg_addr == tmr0_pkg::ADDR_CONTROL;
        nxt_ctl = ctl_wr ? {1'b0, reg_wdata[6:0]} : ctl_ff;
        nxt_msk = msk_ff;
        if (reg_wr && reg_addr == tmr0_pkg::ADDR_IRQ_MASK) begin
            nxt_msk = reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctl_ff <= tmr0_pkg::RESET_CONTROL;
            msk_ff <= tmr0_pkg::RESET_IRQ_MASK;
        end else begin
            ctl_ff <= nxt_ctl;
            msk_ff <= nxt_msk;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    rd_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    ctl_back_a: assert property (
        reg_rd && reg_addr == tmr0_pkg::ADDR_CONTROL
        |=> reg_rdata == $past(ctl_ff))
        else $error("control read back wrong");
    override_a: assert property (
        ctl_wr ##1 !ctl_wr
        |=> compare_output_override == (ctl_ff[5:4] != 2'h0))
        else $error("pin override does not follow output mode");
    force_hit_a: assert property (
        ctl_wr && reg_wdata[7] && !ctl_ff[6] && ctl_ff[5]
        && reg_wdata[6:0] == ctl_ff[6:0]
        |-> ##[1:2] compare_output_pin == ctl_ff[4])
        else $error("forced compare did not reach the pin");
    pwm_force_a: assert property (
        ctl_wr && reg_wdata[7] && ctl_ff[6] && ctl_ff[2:0] == 3'h0
        && reg_wdata[6:0] == ctl_ff[6:0]
        |=> $stable(compare_output_pin) [*2])
        else $error("forced compare acted in a pwm mode");
    cmp_gate_a: assert property (
        cmp_irq_req |-> $past(global_irq_en) && $past(msk_ff[1]))
        else $error("compare request without enables");
    ovf_gate_a: assert property (
        ovf_irq_req |-> $past(global_irq_en) && $past(msk_ff[0]))
        else $error("overflow request without enables");
    cmp_clr_a: assert property (
        cmp_vector_ack && ctl_ff[2:0] == 3'h0
        && $past(ctl_ff[2:0]) == 3'h0 |-> ##2 !cmp_irq_req)
        else $error("compare request not cleared by vector");
endmodule

bind tmr0_ctrl tmr0_chk i_chk (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .global_irq_en(global_irq_en),
    .cmp_vector_ack(cmp_vector_ack), .cmp_irq_req(cmp_irq_req),
    .ovf_irq_req(ovf_irq_req), .compare_output_pin(compare_output_pin),
    .compare_output_override(compare_output_override)
);

//--- tb/tmr0_ctrl_test.sv
// self-checking bench for the timer0 control and compare block
`timescale 1ns/10ps
module tmr0_ctrl_test;
    logic       sys_clk, nrst, reg_wr, reg_rd, global_irq_en;
    logic       cmp_vector_ack, ovf_vector_ack, external_count_pin;
    logic       cmp_irq_req, ovf_irq_req, compare_output_pin;
    logic       compare_output_override;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val;
    int         failures, n_compared;

    tmr0_ctrl i_dut (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .global_irq_en(global_irq_en),
        .cmp_vector_ack(cmp_vector_ack), .ovf_vector_ack(ovf_vector_ack),
        .cmp_irq_req(cmp_irq_req), .ovf_irq_req(ovf_irq_req),
        .external_count_pin(external_count_pin),
        .compare_output_pin(compare_output_pin),
        .compare_output_override(compare_output_override)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic wait_irq(input logic ovf);
        int k;
        k = 0;
        while ((ovf ? ovf_irq_req : cmp_irq_req) !== 1'b1 && k < 600) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 600) begin
            failures++;
            tally_and_finish();
        end
    endtask

    task automatic t_regs();
        for (int a = 0; a < 6; a++) begin
            rd(3'(a));
            chk(rd_val, 8'h00);
        end
        wr(3'h5, 8'h55);
        rd(3'h5);
        chk(rd_val, 8'h00);
        wr(3'h2, 8'hA7);
        rd(3'h2);
        chk(rd_val, 8'hA7);
        wr(3'h1, 8'h5A);
        repeat (20) @(posedge sys_clk);
        rd(3'h1);
        chk(rd_val, 8'h5A);
    endtask

    task automatic t_force();
        logic [7:0] md [4] = '{8'h30, 8'h20, 8'h10, 8'h10};
        logic [7:0] pin [4] = '{8'h01, 8'h00, 8'h01, 8'h00};
        logic       p;
        for (int i = 0; i < 4; i++) begin
            wr(3'h0, md[i]);
            wr(3'h0, md[i] | 8'h80);
            repeat (2) @(posedge sys_clk);
            chk({7'h00, compare_output_pin}, pin[i]);
        end
        chk({7'h00, compare_output_override}, 8'h01);
        rd(3'h0);
        chk(rd_val, 8'h10);
        rd(3'h4);
        chk(rd_val, 8'h00);
        // clear-on-match mode: forcing must not clear the counter
        wr(3'h1, 8'h05);
        wr(3'h0, 8'h18);
        wr(3'h0, 8'h98);
        rd(3'h1);
        chk(rd_val, 8'h05);
        wr(3'h0, 8'h68);
        p = compare_output_pin;
        wr(3'h0, 8'hE8);
        repeat (3) @(posedge sys_clk);
        chk({7'h00, compare_output_pin}, {7'h00, p});
        wr(3'h0, 8'h00);
    endtask

    task automatic t_prescale();
        int n [5] = '{1, 8, 64, 256, 1024};
        for (int i = 0; i < 5; i++) begin
            wr(3'h1, 8'h00);
            wr(3'h0, 8'(i + 1));
            repeat (4 * n[i] - 2) @(posedge sys_clk);
            wr(3'h0, 8'h00);
            rd(3'h1);
            chk({7'h00, rd_val > 8'h01 && rd_val < 8'h07}, 8'h01);
        end
    endtask

    task automatic t_extern();
        for (int i = 6; i < 8; i++) begin
            wr(3'h1, 8'h00);
            wr(3'h0, 8'(i));
            repeat (3) begin
                repeat (4) @(posedge sys_clk);
                external_count_pin <= 1'b1;
                repeat (4) @(posedge sys_clk);
                external_count_pin <= 1'b0;
            end
            repeat (8) @(posedge sys_clk);
            wr(3'h0, 8'h00);
            rd(3'h1);
            chk(rd_val, 8'h03);
        end
    endtask

    task automatic t_irq();
        wr(3'h2, 8'h10);
        wr(3'h1, 8'h00);
        wr(3'h3, 8'h02);
        global_irq_en <= 1'b1;
        wr(3'h0, 8'h11);
        wait_irq(1'b0);
        wr(3'h0, 8'h10);
        rd(3'h4);
        chk(rd_val & 8'h02, 8'h02);
        @(posedge sys_clk);
        cmp_vector_ack <= 1'b1;
        @(posedge sys_clk);
        cmp_vector_ack <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({7'h00, cmp_irq_req}, 8'h00);
        wr(3'h3, 8'h01);
        wr(3'h0, 8'h01);
        wait_irq(1'b1);
        global_irq_en <= 1'b0;
        wr(3'h0, 8'h00);
        chk({7'h00, ovf_irq_req}, 8'h00);
        @(posedge sys_clk);
        ovf_vector_ack <= 1'b1;
        @(posedge sys_clk);
        ovf_vector_ack <= 1'b0;
        rd(3'h4);
        chk(rd_val, 8'h00);
        // counter written to the compare value: that tick must not match
        wr(3'h1, 8'h10);
        wr(3'h0, 8'h01);
        wr(3'h0, 8'h00);
        rd(3'h4);
        chk(rd_val, 8'h00);
        // counter one below the compare value: one blocked tick, then a real match
        wr(3'h1, 8'h0F);
        wr(3'h0, 8'h01);
        wr(3'h0, 8'h00);
        rd(3'h4);
        chk(rd_val, 8'h02);
        wr(3'h4, 8'h03);
        rd(3'h4);
        chk(rd_val, 8'h00);
    endtask

    // high-time over 1020 cycles, two phase-correct or almost four fast PWM periods; edges allow a few ticks
    task automatic t_pwm();
        logic [7:0] c [6] = '{8'h40, 8'h40, 8'hFF, 8'h40, 8'h40, 8'hFF};
        logic [7:0] m [6] = '{8'h69, 8'h79, 8'h69, 8'h61, 8'h71, 8'h61};
        int         e [6] = '{259, 761, 1020, 256, 764, 1020};
        int         h;
        logic       ok;
        for (int i = 0; i < 6; i++) begin
            wr(3'h0, 8'h00);
            wr(3'h1, 8'h00);
            wr(3'h2, c[i]);
            wr(3'h0, m[i]);
            repeat (600) @(posedge sys_clk);
            h = 0;
            repeat (1020) begin
                @(posedge sys_clk);
                h += int'(compare_output_pin);
            end
            ok = h > e[i] - 9 && h < e[i] + 9;
            chk({7'h00, ok}, 8'h01);
        end
        wr(3'h0, 8'h00);
    endtask

    initial begin
        {nrst, reg_wr, reg_rd, global_irq_en} = 4'h0;
        {cmp_vector_ack, ovf_vector_ack, external_count_pin} = 3'h0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        failures = 0;
        n_compared = 0;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        t_regs();
        t_force();
        t_prescale();
        t_extern();
        t_irq();
        t_pwm();
        tally_and_finish();
    end
endmodule
